// ---- rtl/pwg_top.sv ----
// Added by the designer: the address-and-strobe port and the address map.
module pwg_top (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        srst_in,
  // register port
  input  wire logic [pwg_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]                 reg_wdata_in,
  input  wire logic                        reg_write_in,
  input  wire logic                        reg_read_in,
  output logic      [31:0]                 reg_rdata_out,
  // waveforms and request
  output logic      [pwg_pkg::NUM_CH-1:0]  waveform_out,
  output logic                             irq_out
);
  import pwg_pkg::*;

  // -------------------------------------------------------
  // register state
  // -------------------------------------------------------
  logic [7:0]        divider_a_factor;
  logic [3:0]        divider_a_source;
  logic [7:0]        divider_b_factor;
  logic [3:0]        divider_b_source;
  logic              clk_run;
  logic [NUM_CH-1:0] chan_enable;
  logic [NUM_CH-1:0] irq_mask;
  logic [NUM_CH-1:0] channel_event_status;
  logic [NUM_CH-1:0] period_end;
  logic [NUM_CH-1:0] upd_pending;
  logic [3:0]        chan_clock_select    [NUM_CH];
  logic              alignment_select     [NUM_CH];
  logic              start_level_select   [NUM_CH];
  logic              update_target_select [NUM_CH];
  logic [CNT_W-1:0]  period_value         [NUM_CH];
  logic [CNT_W-1:0]  duty_value           [NUM_CH];
  logic [CNT_W-1:0]  update_holding       [NUM_CH];
  logic [CNT_W-1:0]  counter              [NUM_CH];
  logic              count_down           [NUM_CH];
  logic [NUM_CH-1:0] ch_tick;
  logic              wr_mode;
  logic              wr_ena;
  logic              wr_dis;
  logic              wr_ien;
  logic              wr_idis;
  logic              wr_gate;
  logic              rd_event;
  logic [NUM_CH-1:0] ch_hit;
  logic [4:0]        ch_off;

  pwg_tick_if ticks ();

  // clock generator instance
  pwg_clkgen u_clkgen (
    .core_clk_in     (core_clk_in),
    .srst_in         (srst_in),
    .clk_run_in      (clk_run),
    .div_a_factor_in (divider_a_factor),
    .div_a_source_in (divider_a_source),
    .div_b_factor_in (divider_b_factor),
    .div_b_source_in (divider_b_source),
    .ticks           (ticks)
  );

  // -------------------------------------------------------
  // address decode
  // -------------------------------------------------------
  assign wr_mode  = reg_write_in && reg_addr_in == OFS_MODE;
  assign wr_ena   = reg_write_in && reg_addr_in == OFS_ENA;
  assign wr_dis   = reg_write_in && reg_addr_in == OFS_DIS;
  assign wr_ien   = reg_write_in && reg_addr_in == OFS_IEN;
  assign wr_idis  = reg_write_in && reg_addr_in == OFS_IDIS;
  assign wr_gate  = reg_write_in && reg_addr_in == OFS_CLK_GATE;
  assign rd_event = reg_read_in && reg_addr_in == OFS_EVENT;
  assign ch_off   = reg_addr_in[4:0];

  // -------------------------------------------------------
  // global registers
  // -------------------------------------------------------
  // mode register; writes work even when gated
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      divider_a_factor <= 8'h00;
      divider_a_source <= 4'h0;
      divider_b_factor <= 8'h00;
      divider_b_source <= 4'h0;
    end else if (wr_mode) begin
      divider_a_factor <= reg_wdata_in[FACT_A_LSB +: 8];
      divider_a_source <= reg_wdata_in[SRC_A_LSB +: 4];
      divider_b_factor <= reg_wdata_in[FACT_B_LSB +: 8];
      divider_b_source <= reg_wdata_in[SRC_B_LSB +: 4];
    end
  end

  // peripheral clock gate stands in for the power manager
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      clk_run <= 1'b1;
    else if (wr_gate)
      clk_run <= reg_wdata_in[0];
  end

  // channel enables; one write starts several together
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      chan_enable <= '0;
    else if (wr_ena)
      chan_enable <= chan_enable | reg_wdata_in[NUM_CH-1:0];
    else if (wr_dis)
      chan_enable <= chan_enable & ~reg_wdata_in[NUM_CH-1:0];
  end

  // interrupt mask
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      irq_mask <= '0;
    else if (wr_ien)
      irq_mask <= irq_mask | reg_wdata_in[NUM_CH-1:0];
    else if (wr_idis)
      irq_mask <= irq_mask & ~reg_wdata_in[NUM_CH-1:0];
  end

  // period-end flags; read clears, a new event wins
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      channel_event_status <= '0;
    else
      channel_event_status <= (rd_event ? '0 : channel_event_status)
                              | period_end;
  end

  // request line from register
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_mask & ((rd_event ? '0 : channel_event_status)
                               | period_end));
  end

  // -------------------------------------------------------
  // channels
  // -------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [11:0] BASE = OFS_CH_BASE + 12'(c) * CH_STRIDE;
      logic        wr_cmode;
      logic        wr_duty;
      logic        wr_per;
      logic        wr_upd;
      logic        at_top;
      logic        at_end;
      logic        level;
      assign ch_hit[c] = reg_addr_in[ADDR_W-1:5] == BASE[ADDR_W-1:5];
      assign wr_cmode  = reg_write_in & ch_hit[c] & ch_off == OFS_CH_MODE;
      assign wr_duty   = reg_write_in & ch_hit[c] & ch_off == OFS_CH_DUTY;
      assign wr_per    = reg_write_in & ch_hit[c] & ch_off == OFS_CH_PER;
      assign wr_upd    = reg_write_in & ch_hit[c] & ch_off == OFS_CH_UPD;
      assign ch_tick[c] = chan_enable[c] &
          (chan_clock_select[c] < 4'(NUM_CLK_SEL)) &
          ticks.tick[chan_clock_select[c]];
      assign at_top = counter[c] >= period_value[c];
      // end of period in each alignment; left wraps after period ticks
      assign at_end = alignment_select[c] ?
          (count_down[c] && counter[c] <= 16'h0001) ||
          (period_value[c] == 16'h0000) :
          (counter[c] + 16'h0001 >= period_value[c]);
      assign period_end[c] = ch_tick[c] & at_end;

      // mode fields; polarity and alignment only while disabled
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          chan_clock_select[c]    <= 4'h0;
          alignment_select[c]     <= 1'b0;
          start_level_select[c]   <= 1'b0;
          update_target_select[c] <= 1'b0;
        end else if (wr_cmode) begin
          update_target_select[c] <= reg_wdata_in[TARGET_BIT];
          if (!chan_enable[c]) begin
            chan_clock_select[c]  <= reg_wdata_in[CLK_SEL_LSB +: 4];
            alignment_select[c]   <= reg_wdata_in[ALIGN_BIT];
            start_level_select[c] <= reg_wdata_in[LEVEL_BIT];
          end
        end
      end

      // period and duty with buffered update
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          period_value[c]   <= 16'h0000;
          duty_value[c]     <= 16'h0000;
          update_holding[c] <= 16'h0000;
          upd_pending[c]    <= 1'b0;
        end else begin
          if (wr_per && !chan_enable[c])
            period_value[c] <= reg_wdata_in[CNT_W-1:0];
          if (wr_duty && !chan_enable[c])
            duty_value[c] <= reg_wdata_in[CNT_W-1:0];
          if (wr_upd) begin
            update_holding[c] <= reg_wdata_in[CNT_W-1:0];
            upd_pending[c]    <= 1'b1;
          end else if (upd_pending[c] && (period_end[c] ||
                                          !chan_enable[c])) begin
            upd_pending[c] <= 1'b0;
            if (update_target_select[c])
              period_value[c] <= update_holding[c];
            else
              duty_value[c] <= update_holding[c];
          end
        end
      end

      // 16-bit counter; cleared while disabled, held while gated
      always_ff @(posedge core_clk_in) begin
        if (srst_in || !chan_enable[c]) begin
          counter[c]    <= 16'h0000;
          count_down[c] <= 1'b0;
        end else if (ch_tick[c]) begin
          if (alignment_select[c]) begin
            if (at_end) begin
              counter[c]    <= 16'h0000;
              count_down[c] <= 1'b0;
            end else if (!count_down[c] && at_top) begin
              counter[c]    <= counter[c] - 16'h0001;
              count_down[c] <= 1'b1;
            end else if (count_down[c])
              counter[c] <= counter[c] - 16'h0001;
            else
              counter[c] <= counter[c] + 16'h0001;
          end else
            counter[c] <= at_end ? 16'h0000 : counter[c] + 16'h0001;
        end
      end

      // start level for duty ticks; down ramp mirrors the up ramp
      assign level = (count_down[c] ? counter[c] <= duty_value[c]
                                    : counter[c] < duty_value[c]) ?
                     start_level_select[c] : ~start_level_select[c];

      always_ff @(posedge core_clk_in) begin
        if (srst_in)
          waveform_out[c] <= 1'b0;
        else if (!chan_enable[c])
          waveform_out[c] <= start_level_select[c];
        else if (duty_value[c] == period_value[c])
          waveform_out[c] <= start_level_select[c];
        else if (duty_value[c] == 16'h0000)
          waveform_out[c] <= ~start_level_select[c];
        else
          waveform_out[c] <= level;
      end
    end
  endgenerate

  // -------------------------------------------------------
  // read data
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      reg_rdata_out <= RST_VAL;
    else if (!reg_read_in)
      reg_rdata_out <= RST_VAL;
    else begin
      reg_rdata_out <= RST_VAL;
      unique case (reg_addr_in)
        OFS_MODE:
          reg_rdata_out <= {4'h0, divider_b_source, divider_b_factor,
                            4'h0, divider_a_source, divider_a_factor};
        OFS_STATUS:   reg_rdata_out <= {28'h0, chan_enable};
        OFS_IMASK:    reg_rdata_out <= {28'h0, irq_mask};
        OFS_EVENT:    reg_rdata_out <= {28'h0, channel_event_status};
        OFS_CLK_GATE: reg_rdata_out <= {31'h0, clk_run};
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (ch_hit[i]) begin
              if (ch_off == OFS_CH_MODE)
                reg_rdata_out <= {21'h0, update_target_select[i],
                                  start_level_select[i],
                                  alignment_select[i], 4'h0,
                                  chan_clock_select[i]};
              else if (ch_off == OFS_CH_DUTY)
                reg_rdata_out <= {16'h0, duty_value[i]};
              else if (ch_off == OFS_CH_PER)
                reg_rdata_out <= {16'h0, period_value[i]};
              else if (ch_off == OFS_CH_CNT)
                reg_rdata_out <= {16'h0, counter[i]};
            end
          end
        end
      endcase
    end
  end
endmodule : pwg_top

// ---- pkg/pwg_pkg.sv ----
// Contract
// - one clock generator and four channels, each driving its own output pin
// - generator offers thirteen clocks; each channel picks any one independently
// - prescaler gives eleven clocks, master divided by one through 1024
// - two linear dividers give divided clocks a and b, factor 1 to 255
// - each divider divides the prescaler output chosen by its source field
// - reset clears divider factors and sources, stopping both divided clocks
// - at reset or clock gating all prescaler outputs but undivided stop; gating stops the undivided one too
// - channel counter clocked by the output its clock select names; resets 0
// - each channel has a 16-bit counter stepping up or down
// - center mode counts up to period then down to zero, ending period
// - left mode counts up to period then restarts, ending period
// - center period is twice left period for same clock and period
// - duty value compared with counter sets high and low proportion
// - start level select sets level at period start; default starts low
// - alignment select picks left or center; left after reset
// - output fixed low for duty=period,level0 or duty=0,level1
// - output fixed high for duty=0,level0 or duty=period,level1 when enabled
// - polarity set while disabled acts at once; ignored while enabled
// - period and duty double buffered; no mid-period corruption
// - clock stop and restart keeps state and resumes where it stopped
// - configuration writes accepted while peripheral clock is gated off
// - all software access goes through mapped registers
// - update holding value waits for period end, then loads period or duty; loads at once while the channel is disabled
// - period-end flag raises masked request until event register read clears it
// - channels enabled by one enable write start together
package pwg_pkg;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned NUM_PRE      = 11;
  localparam int unsigned NUM_CLK_SEL  = 13;
  localparam int unsigned ADDR_W       = 12;
  // global registers
  localparam logic [11:0] OFS_MODE     = 12'h000;
  localparam logic [11:0] OFS_ENA      = 12'h004;
  localparam logic [11:0] OFS_DIS      = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00c;
  localparam logic [11:0] OFS_IEN      = 12'h010;
  localparam logic [11:0] OFS_IDIS     = 12'h014;
  localparam logic [11:0] OFS_IMASK    = 12'h018;
  localparam logic [11:0] OFS_EVENT    = 12'h01c;
  localparam logic [11:0] OFS_CLK_GATE = 12'h020;
  // channel registers: base + channel * stride
  localparam logic [11:0] OFS_CH_BASE  = 12'h200;
  localparam logic [11:0] CH_STRIDE    = 12'h020;
  localparam logic [4:0]  OFS_CH_MODE  = 5'h00;
  localparam logic [4:0]  OFS_CH_DUTY  = 5'h04;
  localparam logic [4:0]  OFS_CH_PER   = 5'h08;
  localparam logic [4:0]  OFS_CH_CNT   = 5'h0c;
  localparam logic [4:0]  OFS_CH_UPD   = 5'h10;
  // mode register fields
  localparam int unsigned FACT_A_LSB   = 0;
  localparam int unsigned SRC_A_LSB    = 8;
  localparam int unsigned FACT_B_LSB   = 16;
  localparam int unsigned SRC_B_LSB    = 24;
  // channel mode fields
  localparam int unsigned CLK_SEL_LSB  = 0;
  localparam int unsigned ALIGN_BIT    = 8;
  localparam int unsigned LEVEL_BIT    = 9;
  localparam int unsigned TARGET_BIT   = 10;
  localparam logic [3:0]  SEL_DIV_A    = 4'hb;
  localparam logic [3:0]  SEL_DIV_B    = 4'hc;
  localparam logic [31:0] RST_VAL      = 32'h0000_0000;
endpackage : pwg_pkg

// ---- pkg/pwg_tick_if.sv ----
// clock enables from the generator to the channels
interface pwg_tick_if;
  import pwg_pkg::*;
  logic [NUM_CLK_SEL-1:0] tick;
  modport gen (output tick);
  modport chan (input tick);
endinterface : pwg_tick_if

// ---- rtl/pwg_clkgen.sv ----
module pwg_clkgen (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  // gating and settings
  input  wire logic       clk_run_in,
  input  wire logic [7:0] div_a_factor_in,
  input  wire logic [3:0] div_a_source_in,
  input  wire logic [7:0] div_b_factor_in,
  input  wire logic [3:0] div_b_source_in,
  // tick outputs
  pwg_tick_if.gen         ticks
);
  import pwg_pkg::*;
  logic [NUM_PRE-2:0] pre_cnt;
  logic [NUM_PRE-1:0] pre_tick;
  logic [7:0]         div_a_cnt;
  logic [7:0]         div_b_cnt;
  logic               src_a;
  logic               src_b;

  // -------------------------------------------------------
  // prescaler
  // -------------------------------------------------------
  // counter held at reset and while gated: divided ticks stop
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      pre_cnt <= '0;
    else if (clk_run_in)
      pre_cnt <= pre_cnt + 1'b1;
  end

  // tick for divide-by-2^k when low k bits all ones
  assign pre_tick[0] = clk_run_in;
  genvar k;
  generate
    for (k = 1; k < NUM_PRE; k++) begin : g_pre
      assign pre_tick[k] = clk_run_in & (&pre_cnt[k-1:0]);
    end
  endgenerate

  assign src_a = (div_a_source_in < 4'(NUM_PRE)) ?
                 pre_tick[div_a_source_in] : 1'b0;
  assign src_b = (div_b_source_in < 4'(NUM_PRE)) ?
                 pre_tick[div_b_source_in] : 1'b0;

  // -------------------------------------------------------
  // linear dividers
  // -------------------------------------------------------
  // factor zero keeps divider stopped
  always_ff @(posedge core_clk_in) begin
    if (srst_in || div_a_factor_in == 8'h00)
      div_a_cnt <= 8'h00;
    else if (src_a)
      div_a_cnt <= (div_a_cnt + 8'h01 >= div_a_factor_in) ?
                   8'h00 : div_a_cnt + 8'h01;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in || div_b_factor_in == 8'h00)
      div_b_cnt <= 8'h00;
    else if (src_b)
      div_b_cnt <= (div_b_cnt + 8'h01 >= div_b_factor_in) ?
                   8'h00 : div_b_cnt + 8'h01;
  end

  // thirteen selectable ticks
  assign ticks.tick = {
    src_b & (div_b_factor_in != 8'h00) &
      (div_b_cnt + 8'h01 >= div_b_factor_in),
    src_a & (div_a_factor_in != 8'h00) &
      (div_a_cnt + 8'h01 >= div_a_factor_in),
    pre_tick};
endmodule : pwg_clkgen

// ---- sim/pwg_monitor.sv ----
module pwg_monitor (
  // clock and reset
  input wire logic                       core_clk_in,
  input wire logic                       srst_in,
  // register port
  input wire logic [pwg_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0]                reg_wdata_in,
  input wire logic                       reg_write_in,
  input wire logic                       reg_read_in,
  input wire logic [31:0]                reg_rdata_out,
  // waveforms and request
  input wire logic [pwg_pkg::NUM_CH-1:0] waveform_out,
  input wire logic                       irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import pwg_pkg::*;
  logic [3:0]  en_q;
  logic [3:0]  msk_q;
  logic [3:0]  lvl_q;
  logic [31:0] mode_q;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  // ------
  // shadow state
  // ------
  // enables, mask and divider settings as software wrote them
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      en_q   <= '0;
      msk_q  <= '0;
      mode_q <= '0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        OFS_ENA:  en_q <= en_q | reg_wdata_in[3:0];
        OFS_DIS:  en_q <= en_q & ~reg_wdata_in[3:0];
        OFS_IEN:  msk_q <= msk_q | reg_wdata_in[3:0];
        OFS_IDIS: msk_q <= msk_q & ~reg_wdata_in[3:0];
        OFS_MODE: mode_q <= reg_wdata_in & 32'h0fff_0fff;
        default:  ;
      endcase
    end
  end
  // start level only follows writes while the channel is off
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (srst_in) begin
        lvl_q[i] <= 1'b0;
      end else if (reg_write_in && !en_q[i]
                   && reg_addr_in == OFS_CH_BASE + 12'(i) * CH_STRIDE) begin
        lvl_q[i] <= reg_wdata_in[LEVEL_BIT];
      end
    end
  end

  // ------
  // assertions
  // ------
  a_idle_rdata:
    assert property (!$past(reg_read_in) |-> reg_rdata_out == '0)
    else $error("read data not zero outside a read answer");
  a_reset_quiet:
    assert property ($past(srst_in) |-> waveform_out == '0 && !irq_out)
    else $error("outputs not quiet after reset");
  a_unmapped_zero:
    assert property ($past(reg_read_in)
      && $past(reg_addr_in) inside {[12'h024:12'h1fc]}
      |-> reg_rdata_out == '0)
    else $error("reserved address read not zero");
  a_status_back:
    assert property ($past(reg_read_in) && $past(reg_addr_in) == OFS_STATUS
      |-> reg_rdata_out == {28'h0, $past(en_q)})
    else $error("status read differs from enables");
  a_mask_back:
    assert property ($past(reg_read_in) && $past(reg_addr_in) == OFS_IMASK
      |-> reg_rdata_out == {28'h0, $past(msk_q)})
    else $error("mask read differs from written mask");
  a_mode_back:
    assert property ($past(reg_read_in) && $past(reg_addr_in) == OFS_MODE
      |-> reg_rdata_out == $past(mode_q))
    else $error("divider settings read back wrong");
  a_irq_masked:
    assert property (irq_out |-> ($past(msk_q) | msk_q) != '0)
    else $error("request raised with every channel masked");
  for (genvar i = 0; i < 4; i++) begin : g_ch
    a_off_level:
      assert property (!en_q[i] && !$past(en_q[i]) && $stable(lvl_q[i])
        |-> waveform_out[i] == lvl_q[i])
      else $error("disabled channel not at its start level");
  end
endmodule : pwg_monitor

bind pwg_top pwg_monitor u_mon (
  .core_clk_in   (core_clk_in),
  .srst_in       (srst_in),
  .reg_addr_in   (reg_addr_in),
  .reg_wdata_in  (reg_wdata_in),
  .reg_write_in  (reg_write_in),
  .reg_read_in   (reg_read_in),
  .reg_rdata_out (reg_rdata_out),
  .waveform_out  (waveform_out),
  .irq_out       (irq_out)
);

// ---- sim/pwg_load.sv ----
module pwg_load (
  // clock and window
  input  wire logic              clk_in,
  input  wire logic              win_in,
  // waveform pins
  input  wire logic [3:0]        pin_in,
  // counts over the window
  output logic      [3:0][15:0]  hi_out,
  output logic      [3:0][15:0]  rise_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] prev;
  // high cycles and rising edges seen by each load
  always_ff @(posedge clk_in) begin
    prev <= pin_in;
    for (int i = 0; i < 4; i++) begin
      if (!win_in) begin
        hi_out[i]   <= '0;
        rise_out[i] <= '0;
      end else begin
        hi_out[i]   <= hi_out[i] + 16'(pin_in[i]);
        rise_out[i] <= rise_out[i] + 16'(pin_in[i] & ~prev[i]);
      end
    end
  end
endmodule : pwg_load

// ---- sim/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pwg_pkg::*;
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic [11:0]      addr = '0;
  logic [31:0]      wd = '0;
  logic             wen = 1'b0;
  logic             ren = 1'b0;
  logic             win = 1'b0;
  logic [31:0]      rdata;
  logic [3:0]       wf;
  logic             irq;
  logic [3:0][15:0] hi;
  logic [3:0][15:0] rise;
  int               n_mismatch = 0;
  int               n_checks = 0;
  int               cyc = 0;
  // channel, clock select, center, start level, period, duty
  int rows [8][6] = '{'{0, 0, 0, 0, 10, 3}, '{1, 1, 1, 1, 8, 2},
    '{2, 2, 0, 1, 5, 5}, '{3, 0, 0, 0, 6, 0}, '{0, 0, 1, 0, 7, 7},
    '{1, 0, 0, 1, 4, 0}, '{2, 11, 0, 0, 4, 1}, '{3, 12, 1, 1, 3, 1}};

  pwg_top uut (
    .core_clk_in   (clk),
    .srst_in       (srst),
    .reg_addr_in   (addr),
    .reg_wdata_in  (wd),
    .reg_write_in  (wen),
    .reg_read_in   (ren),
    .reg_rdata_out (rdata),
    .waveform_out  (wf),
    .irq_out       (irq)
  );
  pwg_load u_load (
    .clk_in   (clk),
    .win_in   (win),
    .pin_in   (wf),
    .hi_out   (hi),
    .rise_out (rise)
  );

  // ------
  // clock and watchdog
  // ------
  initial begin
    forever #2.5 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  // ------
  // tasks
  // ------
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdc
  function automatic logic [11:0] ca(input int c, input logic [4:0] o);
    return OFS_CH_BASE + CH_STRIDE * 12'(c) + 12'(o);
  endfunction : ca
  // settle two periods, then count over three whole periods
  task automatic meas(input int c, input int t, input int h, input int r);
    repeat (2 * t) @(posedge clk);
    win <= 1'b1;
    repeat (3 * t) @(posedge clk);
    win <= 1'b0;
    #1 chk(32'(hi[c]), 32'(3 * h));
    chk(32'(rise[c]), 32'(3 * r));
  endtask : meas
  task automatic run(input int c, s, al, lv, p, d);
    int tk;
    int m;
    tk = (s < 11) ? (1 << s) : ((s == 11) ? 6 : 2);
    m = tk * (al + 1);
    wr(ca(c, OFS_CH_MODE), 32'(s) | 32'(al << ALIGN_BIT | lv << LEVEL_BIT));
    wr(ca(c, OFS_CH_DUTY), 32'(d));
    wr(ca(c, OFS_CH_PER), 32'(p));
    wr(OFS_ENA, 32'h1 << c);
    rdc(OFS_STATUS, 32'h1 << c);
    meas(c, p * m, (lv ? d : p - d) * m, (d > 0 && d < p) ? 1 : 0);
    wr(OFS_DIS, 32'h1 << c);
  endtask : run

  // ------
  // main sequence
  // ------
  initial begin
    logic [31:0] v1;
    logic [31:0] v2;
    int          dif;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1 chk(32'(wf), 32'h0);
    rdc(OFS_MODE, 32'h0);
    rdc(ca(0, OFS_CH_MODE), 32'h0);
    rdc(OFS_IMASK, 32'h0);
    wr(12'h100, 32'hffff_ffff);
    rdc(12'h100, 32'h0);
    // divided a: master/2 by 3, divided b: master by 2
    wr(OFS_MODE, 32'h0002_0103);
    rdc(OFS_MODE, 32'h0002_0103);
    foreach (rows[r]) begin
      run(rows[r][0], rows[r][1], rows[r][2], rows[r][3], rows[r][4],
          rows[r][5]);
    end
    for (int k = 0; k < 11; k++) begin
      run(k % 4, k, 0, 0, 2, 1);
    end
    // start level acts at once while off, ignored while on
    wr(ca(0, OFS_CH_MODE), 32'h200);
    repeat (2) @(posedge clk);
    #1 chk(32'(wf[0]), 32'h1);
    wr(ca(0, OFS_CH_DUTY), 32'd4);
    wr(ca(0, OFS_CH_PER), 32'd4);
    wr(OFS_ENA, 32'h1);
    wr(ca(0, OFS_CH_MODE), 32'h0);
    wr(ca(0, OFS_CH_PER), 32'd9);
    rdc(ca(0, OFS_CH_MODE), 32'h200);
    rdc(ca(0, OFS_CH_PER), 32'd4);
    chk(32'(wf[0]), 32'h1);
    wr(OFS_DIS, 32'h1);
    // held updates to duty then period; period-end request
    rd(OFS_EVENT, v1);
    wr(ca(0, OFS_CH_MODE), 32'h0);
    wr(ca(0, OFS_CH_DUTY), 32'd3);
    wr(ca(0, OFS_CH_PER), 32'd10);
    wr(OFS_IEN, 32'h1);
    wr(OFS_ENA, 32'h1);
    wr(ca(0, OFS_CH_UPD), 32'd6);
    meas(0, 10, 4, 1);
    wr(ca(0, OFS_CH_MODE), 32'h400);
    wr(ca(0, OFS_CH_UPD), 32'd20);
    meas(0, 20, 14, 1);
    rdc(OFS_IMASK, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_DIS, 32'h1);
    rdc(OFS_EVENT, 32'h1);
    rdc(OFS_EVENT, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_IDIS, 32'h1);
    // two channels started by one write stay in step
    for (int c = 1; c < 3; c++) begin
      wr(ca(c, OFS_CH_MODE), 32'h0);
      wr(ca(c, OFS_CH_DUTY), 32'd3);
      wr(ca(c, OFS_CH_PER), 32'd10);
    end
    wr(OFS_ENA, 32'h6);
    dif = 0;
    repeat (30) begin
      @(posedge clk);
      #1 dif = dif + int'(wf[1] !== wf[2]);
    end
    chk(32'(dif), 32'h0);
    // stopped clock freezes the count, keeps accepting settings
    wr(OFS_CLK_GATE, 32'h0);
    repeat (3) @(posedge clk);
    rd(ca(1, OFS_CH_CNT), v1);
    wr(OFS_MODE, 32'h0001_0204);
    rdc(OFS_MODE, 32'h0001_0204);
    repeat (20) @(posedge clk);
    rdc(ca(1, OFS_CH_CNT), v1);
    wr(OFS_CLK_GATE, 32'h1);
    repeat (5) @(posedge clk);
    rd(ca(1, OFS_CH_CNT), v2);
    chk(32'(v2 !== v1), 32'h1);
    // second reset in mid run
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 chk(32'(wf), 32'h0);
    rdc(OFS_MODE, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    report_and_stop();
  end
endmodule : tb
